// >>> verilog/btc_regs.vh
// offsets, field positions, reset values and codes for the bus cycle timing block
// Notes on behaviour
// - write timing register resets to 07h, byte wide
// - select bit 0 late write, 1 early write
// - early write three clocks, late write two
// - io zone register resets 069Fh, covers FFFBxxh
// - io zone adds zero to seven wait cycles
// - hold field adds zero to three hold cycles
// - waits after address, holds at cycle end
// - io width bit: 0 byte, 1 word bus
// - post idle adds idle after cycle, new zone
// - zone0 register resets 069Fh, covers on-chip flash
// - zone0 adds zero to seven wait cycles
// - fast read ignores zone0 wait and hold
// - fast read one clock, normal read two+
// - burst read on byte regions, off if fast
// - burst wait adds one clock to burst
// - pre idle inserts idle before different zone
`ifndef BTC_REGS_VH
`define BTC_REGS_VH

// register indices, byte address is four times the index
`define BTC_IDX_WTS   8'h00
`define BTC_IDX_IO    8'h02
`define BTC_IDX_Z0    8'h04
`define BTC_IDX_STAT  8'h06

// reset values
`define BTC_WTS_RST   8'h07
`define BTC_IO_RST    16'h069f
`define BTC_Z0_RST    16'h069f

// field positions
`define BTC_F_EARLY   0
`define BTC_F_WAIT_HI 2
`define BTC_F_WAIT_LO 0
`define BTC_F_HOLD_HI 4
`define BTC_F_HOLD_LO 3
`define BTC_F_BURST   5
`define BTC_F_BWAIT   6
`define BTC_F_WIDTH   7
`define BTC_F_POST    9
`define BTC_F_PRE     10
`define BTC_F_FAST    11

// zone windows
`define BTC_IO_LO     24'hfffb00
`define BTC_IO_HI     24'hfffbff
`define BTC_Z0A_LO    24'h000000
`define BTC_Z0A_HI    24'h03ffff
`define BTC_Z0B_LO    24'h0d0000
`define BTC_Z0B_HI    24'h0d1fff

// zone codes
`define BTC_ZN_Z0     2'h0
`define BTC_ZN_IO     2'h1
`define BTC_ZN_OTH    2'h2

// bus phase codes
`define BTC_PH_IDLE   3'h0
`define BTC_PH_ADDR   3'h1
`define BTC_PH_WAIT   3'h2
`define BTC_PH_DATA   3'h3
`define BTC_PH_HOLD   3'h4
`define BTC_PH_BWAIT  3'h5
`define BTC_PH_GAP    3'h6

`endif

// >>> verilog/btc_zone_sel.v
// zone decode and selection of the timing fields that apply to one access
`timescale 1ns/1ps
`default_nettype none
`include "btc_regs.vh"
module btc_zone_sel (
    input  wire [23:0] addr,
    input  wire        wr,
    input  wire [15:0] io_cfg,
    input  wire [15:0] z0_cfg,
    output reg  [1:0]  zone,
    output reg  [2:0]  wait_n,
    output reg  [1:0]  hold_n,
    output reg         narrow,
    output reg         fast,
    output reg         burst,
    output reg         bwait,
    output reg         post,
    output reg         pre
);
    // fast read bit masks wait and hold for reads and writes alike
    wire z0_fast = z0_cfg[`BTC_F_FAST];

    // pick the zone, then the fields of that zone's register
    always @* begin
        zone   = `BTC_ZN_OTH;
        wait_n = 3'h0;
        hold_n = 2'h0;
        narrow = 1'b0;
        fast   = 1'b0;
        burst  = 1'b0;
        bwait  = 1'b0;
        post   = 1'b0;
        pre    = 1'b0;
        if (addr >= `BTC_IO_LO && addr <= `BTC_IO_HI) begin
            zone   = `BTC_ZN_IO;
            wait_n = io_cfg[`BTC_F_WAIT_HI:`BTC_F_WAIT_LO];
            hold_n = io_cfg[`BTC_F_HOLD_HI:`BTC_F_HOLD_LO];
            narrow = ~io_cfg[`BTC_F_WIDTH];
            post   = io_cfg[`BTC_F_POST];
        end else if ((addr <= `BTC_Z0A_HI) ||
                     (addr >= `BTC_Z0B_LO && addr <= `BTC_Z0B_HI)) begin
            zone   = `BTC_ZN_Z0;
            fast   = z0_fast & ~wr;
            // fast read bit masks wait, hold and burst settings
            wait_n = z0_fast ? 3'h0 : z0_cfg[`BTC_F_WAIT_HI:`BTC_F_WAIT_LO];
            hold_n = z0_fast ? 2'h0 : z0_cfg[`BTC_F_HOLD_HI:`BTC_F_HOLD_LO];
            narrow = ~z0_cfg[`BTC_F_WIDTH];
            burst  = z0_cfg[`BTC_F_BURST] & ~z0_fast & ~wr;
            bwait  = burst & z0_cfg[`BTC_F_BWAIT];
            post   = z0_cfg[`BTC_F_POST];
            pre    = z0_cfg[`BTC_F_PRE];
        end
    end
endmodule // btc_zone_sel
`default_nettype wire

// >>> verilog/btc_apb_regs.v
// apb slave holding the three timing registers and a status word
`timescale 1ns/1ps
`default_nettype none
`include "btc_regs.vh"
module btc_apb_regs (
    input  wire        core_clk,
    input  wire        arst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [9:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [7:0]  stat,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg  [7:0]  wts_q,
    output reg  [15:0] io_q,
    output reg  [15:0] z0_q
);
    wire       acc    = psel & penable;
    wire       aligned = (paddr[1:0] == 2'h0);
    wire [7:0] idx    = paddr[9:2];
    reg [31:0] rd_d;
    reg        hit_d;

    // read mux and address decode
    always @* begin
        rd_d  = 32'h0;
        hit_d = aligned;
        if (idx == `BTC_IDX_WTS) begin
            rd_d = {29'h0, wts_q[2:0]};
        end else if (idx == `BTC_IDX_IO) begin
            rd_d = {16'h0, io_q};
        end else if (idx == `BTC_IDX_Z0) begin
            rd_d = {16'h0, z0_q};
        end else if (idx == `BTC_IDX_STAT) begin
            rd_d = {24'h0, stat};
        end else begin
            hit_d = 1'b0;
        end
        if (!aligned) begin
            rd_d = 32'h0;
        end
    end

    // one wait state: answer is registered, write lands on the ready edge
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            wts_q   <= `BTC_WTS_RST;
            io_q    <= `BTC_IO_RST;
            z0_q    <= `BTC_Z0_RST;
        end else begin
            pready  <= acc & ~pready;
            pslverr <= acc & ~pready & ~hit_d;
            prdata  <= (acc & ~pready & ~pwrite) ? rd_d : 32'h0;
            if (acc && pready && pwrite && hit_d) begin
                if (idx == `BTC_IDX_WTS) begin
                    // bits 0-2 are kept as software writes them
                    wts_q <= {5'h0, pwdata[2:0]};
                end else if (idx == `BTC_IDX_IO) begin
                    io_q <= pwdata[15:0];
                end else if (idx == `BTC_IDX_Z0) begin
                    z0_q <= pwdata[15:0];
                end
            end
        end
    end
endmodule // btc_apb_regs
`default_nettype wire

// >>> verilog/btc_top.v
// bus cycle shaper: register file, zone timing and the cycle sequencer
`timescale 1ns/1ps
`default_nettype none
`include "btc_regs.vh"
module btc_top (
    input  wire        core_clk,
    input  wire        arst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [9:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        core_req,
    input  wire [23:0] core_addr,
    input  wire        core_wr,
    input  wire        core_wide,
    output reg         core_ack_q,
    output reg  [23:0] bus_addr_q,
    output reg  [2:0]  bus_phase_q,
    output reg         bus_rd_q,
    output reg         bus_wr_q,
    output reg         bus_byte_q,
    output reg         busy_q
);
    // one-hot sequencer states
    localparam [7:0] S_IDLE  = 8'h01;
    localparam [7:0] S_GAP   = 8'h02;
    localparam [7:0] S_ADDR  = 8'h04;
    localparam [7:0] S_WAIT  = 8'h08;
    localparam [7:0] S_BWAIT = 8'h10;
    localparam [7:0] S_DATA  = 8'h20;
    localparam [7:0] S_EXTRA = 8'h40;
    localparam [7:0] S_HOLD  = 8'h80;

    wire [7:0]  wts_q;
    wire [15:0] io_q;
    wire [15:0] z0_q;
    wire [7:0]  stat;

    // decoded view of the incoming request
    wire [1:0]  n_zone;
    wire [2:0]  n_wait;
    wire [1:0]  n_hold;
    wire        n_narrow;
    wire        n_fast;
    wire        n_burst;
    wire        n_bwait;
    wire        n_post;
    wire        n_pre;

    reg  [7:0]  st_q;
    reg  [7:0]  st_d;
    reg  [2:0]  cnt_q;
    reg  [2:0]  cnt_d;
    reg         second_q;
    reg         second_d;
    reg         done_d;
    reg         take_d;

    // settings captured at the start of each bus cycle
    reg  [1:0]  zone_q;
    reg  [2:0]  wait_q;
    reg  [1:0]  hold_q;
    reg         narrow_q;
    reg         fast_q;
    reg         burst_q;
    reg         bwait_q;
    reg         post_q;
    reg         early_q;
    reg         wr_q;
    reg         wide_q;
    reg  [23:0] addr_q;

    // memory of the previous cycle, for idle insertion
    reg  [1:0]  last_zone_q;
    reg         last_post_q;
    reg         last_valid_q;

    wire        zone_change;
    wire [1:0]  gap_n;

    assign stat = {1'b0, last_valid_q, last_zone_q, zone_q, 1'b0, busy_q};

    btc_apb_regs u_regs (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .stat     (stat),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .wts_q    (wts_q),
        .io_q     (io_q),
        .z0_q     (z0_q)
    );

    btc_zone_sel u_sel (
        .addr   (core_addr),
        .wr     (core_wr),
        .io_cfg (io_q),
        .z0_cfg (z0_q),
        .zone   (n_zone),
        .wait_n (n_wait),
        .hold_n (n_hold),
        .narrow (n_narrow),
        .fast   (n_fast),
        .burst  (n_burst),
        .bwait  (n_bwait),
        .post   (n_post),
        .pre    (n_pre)
    );

    // idle clocks only when the zone really changes; the first access has
    // no predecessor, so it never pays for an idle
    assign zone_change = last_valid_q & (n_zone != last_zone_q);
    assign gap_n = {1'b0, zone_change & last_post_q}
                 + {1'b0, zone_change & n_pre};

    // next state of the sequencer
    always @* begin
        st_d     = st_q;
        cnt_d    = cnt_q;
        second_d = second_q;
        done_d   = 1'b0;
        take_d   = 1'b0;
        case (st_q)
            S_IDLE: begin
                // ack cycle blocks a stale request still held high
                if (core_req && !core_ack_q) begin
                    take_d   = 1'b1;
                    second_d = 1'b0;
                    if (gap_n != 2'h0) begin
                        st_d  = S_GAP;
                        cnt_d = {1'b0, gap_n} - 3'h1;
                    end else begin
                        st_d = S_ADDR;
                    end
                end
            end
            S_GAP: begin
                if (cnt_q == 3'h0) begin
                    st_d = S_ADDR;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            S_ADDR: begin
                if (fast_q) begin
                    // single clock read, straight to the end of the byte
                    st_d = S_IDLE;
                    if (wide_q && narrow_q && !second_q) begin
                        st_d     = S_ADDR;
                        second_d = 1'b1;
                    end else begin
                        done_d = 1'b1;
                    end
                end else if (wait_q != 3'h0) begin
                    // waits follow the address clock
                    st_d  = S_WAIT;
                    cnt_d = wait_q - 3'h1;
                end else begin
                    st_d = S_DATA;
                end
            end
            S_WAIT: begin
                if (cnt_q == 3'h0) begin
                    st_d = S_DATA;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            S_BWAIT: begin
                st_d = S_DATA;
            end
            S_DATA: begin
                if (wr_q && early_q) begin
                    st_d = S_EXTRA;
                end else if (hold_q != 2'h0) begin
                    st_d  = S_HOLD;
                    cnt_d = {1'b0, hold_q} - 3'h1;
                end else begin
                    st_d = S_IDLE;
                end
            end
            S_EXTRA: begin
                if (hold_q != 2'h0) begin
                    st_d  = S_HOLD;
                    cnt_d = {1'b0, hold_q} - 3'h1;
                end else begin
                    st_d = S_IDLE;
                end
            end
            S_HOLD: begin
                if (cnt_q == 3'h0) begin
                    st_d = S_IDLE;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            default: begin
                st_d = S_IDLE;
            end
        endcase
        // end of a byte on a narrow zone: second byte or finish
        if (st_d == S_IDLE && st_q != S_IDLE && st_q != S_ADDR) begin
            if (wide_q && narrow_q && !second_q) begin
                second_d = 1'b1;
                if (burst_q) begin
                    // burst skips the address clock and the waits
                    st_d = bwait_q ? S_BWAIT : S_DATA;
                end else begin
                    st_d = S_ADDR;
                end
            end else begin
                done_d = 1'b1;
            end
        end
    end

    // state, counters and the per-cycle snapshot of the settings
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q         <= S_IDLE;
            cnt_q        <= 3'h0;
            second_q     <= 1'b0;
            zone_q       <= `BTC_ZN_OTH;
            wait_q       <= 3'h0;
            hold_q       <= 2'h0;
            narrow_q     <= 1'b0;
            fast_q       <= 1'b0;
            burst_q      <= 1'b0;
            bwait_q      <= 1'b0;
            post_q       <= 1'b0;
            early_q      <= 1'b0;
            wr_q         <= 1'b0;
            wide_q       <= 1'b0;
            addr_q       <= 24'h0;
            last_zone_q  <= `BTC_ZN_OTH;
            last_post_q  <= 1'b0;
            last_valid_q <= 1'b0;
        end else begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            second_q <= second_d;
            // register writes during a cycle wait for the next one
            if (take_d) begin
                zone_q   <= n_zone;
                wait_q   <= n_wait;
                hold_q   <= n_hold;
                narrow_q <= n_narrow;
                fast_q   <= n_fast;
                burst_q  <= n_burst;
                bwait_q  <= n_bwait;
                post_q   <= n_post;
                early_q  <= wts_q[`BTC_F_EARLY];
                wr_q     <= core_wr;
                wide_q   <= core_wide;
                addr_q   <= core_addr;
            end
            if (second_d && !second_q) begin
                addr_q <= addr_q + 24'h1;
            end
            if (done_d) begin
                last_zone_q  <= zone_q;
                last_post_q  <= post_q;
                last_valid_q <= 1'b1;
            end
        end
    end

    // bus side outputs, registered from the next state so they line up
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            core_ack_q  <= 1'b0;
            bus_addr_q  <= 24'h0;
            bus_phase_q <= `BTC_PH_IDLE;
            bus_rd_q    <= 1'b0;
            bus_wr_q    <= 1'b0;
            bus_byte_q  <= 1'b0;
            busy_q      <= 1'b0;
        end else begin
            core_ack_q <= done_d;
            busy_q     <= (st_d != S_IDLE);
            bus_byte_q <= (st_d != S_IDLE) & second_d;
            if (take_d) begin
                bus_addr_q <= core_addr;
            end else if (second_d && !second_q) begin
                bus_addr_q <= addr_q + 24'h1;
            end
            bus_rd_q <= 1'b0;
            bus_wr_q <= 1'b0;
            case (st_d)
                S_GAP: begin
                    bus_phase_q <= `BTC_PH_GAP;
                end
                S_ADDR: begin
                    bus_phase_q <= `BTC_PH_ADDR;
                end
                S_WAIT: begin
                    bus_phase_q <= `BTC_PH_WAIT;
                end
                S_BWAIT: begin
                    bus_phase_q <= `BTC_PH_BWAIT;
                end
                S_DATA: begin
                    bus_phase_q <= `BTC_PH_DATA;
                    bus_rd_q    <= take_d ? ~core_wr : ~wr_q;
                    bus_wr_q    <= take_d ? core_wr : wr_q;
                end
                S_EXTRA: begin
                    bus_phase_q <= `BTC_PH_DATA;
                    bus_wr_q    <= 1'b1;
                end
                S_HOLD: begin
                    // address kept on the bus during hold, both strobes low
                    bus_phase_q <= `BTC_PH_HOLD;
                end
                default: begin
                    bus_phase_q <= `BTC_PH_IDLE;
                end
            endcase
        end
    end
endmodule // btc_top
`default_nettype wire

// >>> dv/btc_assertions.sv
// checker for the bus cycle timing block, attached by bind
`timescale 1ns/1ps
`default_nettype none
`include "btc_regs.vh"
module btc_assertions (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        core_ack_q,
    input wire logic [23:0] bus_addr_q,
    input wire logic [2:0]  bus_phase_q,
    input wire logic        bus_rd_q,
    input wire logic        bus_wr_q,
    input wire logic        bus_byte_q,
    input wire logic        busy_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // register answer comes after exactly one wait state
    property p_apb_wait;
        $rose(penable) && psel |-> !pready ##1 pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing off");
    property p_err_zero;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error without zero data");
    // completion is a lone pulse and ends the cycle
    property p_ack_pulse;
        core_ack_q |-> !busy_q ##1 !core_ack_q;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a pulse");
    // waits sit right behind the address, holds at the end
    property p_wait_pos;
        bus_phase_q == `BTC_PH_WAIT |-> $past(bus_phase_q) inside {`BTC_PH_ADDR, `BTC_PH_WAIT};
    endproperty
    a_wait_pos: assert property (p_wait_pos) else $error("wait not after address");
    property p_addr_held;
        bus_phase_q == `BTC_PH_WAIT |-> $stable(bus_addr_q);
    endproperty
    a_addr_held: assert property (p_addr_held) else $error("address moved in wait");
    property p_hold_pos;
        bus_phase_q == `BTC_PH_HOLD |-> $past(bus_phase_q) inside {`BTC_PH_DATA, `BTC_PH_HOLD};
    endproperty
    a_hold_pos: assert property (p_hold_pos) else $error("hold not after data");
    property p_wait_max;
        (bus_phase_q == `BTC_PH_WAIT) [*7] |=> bus_phase_q != `BTC_PH_WAIT;
    endproperty
    a_wait_max: assert property (p_wait_max) else $error("more than seven waits");
    property p_hold_max;
        (bus_phase_q == `BTC_PH_HOLD) [*3] |=> bus_phase_q != `BTC_PH_HOLD;
    endproperty
    a_hold_max: assert property (p_hold_max) else $error("more than three holds");
    property p_gap_busy;
        bus_phase_q == `BTC_PH_GAP |-> busy_q && !core_ack_q;
    endproperty
    a_gap_busy: assert property (p_gap_busy) else $error("idle clock outside a cycle");
    // exactly one strobe in every data clock, none elsewhere
    property p_strobe_data;
        ((bus_phase_q == `BTC_PH_DATA) == (bus_rd_q || bus_wr_q)) && !(bus_rd_q && bus_wr_q);
    endproperty
    a_strobe_data: assert property (p_strobe_data) else $error("strobe outside data");
    property p_byte_busy;
        bus_byte_q |-> busy_q && bus_phase_q != `BTC_PH_GAP;
    endproperty
    a_byte_busy: assert property (p_byte_busy) else $error("second byte outside a cycle");
    c_byte: cover property (bus_byte_q);
    c_err: cover property (pslverr);
    c_gap: cover property (bus_phase_q == `BTC_PH_GAP);
    c_wait7: cover property ((bus_phase_q == `BTC_PH_WAIT) [*7]);
endmodule // btc_assertions
`default_nettype wire

// >>> dv/btc_core_model.sv
// core bus requester standing on the far side of the cycle shaper
`timescale 1ns/1ps
`default_nettype none
module btc_core_model (
    input  wire logic        core_clk,
    input  wire logic        core_ack_q,
    output logic             core_req,
    output logic [23:0]      core_addr,
    output logic             core_wr,
    output logic             core_wide
);
    initial begin
        core_req = 1'b0;
        core_addr = 24'h0;
        core_wr = 1'b0;
        core_wide = 1'b0;
    end
    // one access held until ack; n counts edges from take to ack seen
    task automatic access(input logic [23:0] a, input logic w, input logic wd, output int n);
        n = 0;
        core_req <= 1'b1;
        core_addr <= a;
        core_wr <= w;
        core_wide <= wd;
        @(posedge core_clk);
        while (core_ack_q !== 1'b1 && n < 200) begin
            n++;
            @(posedge core_clk);
        end
        core_req <= 1'b0;
        core_addr <= ~a; // released bus must not keep a stale address
        @(posedge core_clk);
    endtask
endmodule // btc_core_model
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the bus cycle timing block
`timescale 1ns/1ps
`default_nettype none
`include "btc_regs.vh"
module tb;
    logic        core_clk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         core_req;
    wire  [23:0] core_addr;
    wire         core_wr;
    wire         core_wide;
    wire         core_ack_q;
    wire  [23:0] bus_addr_q;
    wire  [2:0]  bus_phase_q;
    wire         bus_rd_q;
    wire         bus_wr_q;
    wire         bus_byte_q;
    wire         busy_q;
    int          fail_count;
    int          checks;
    localparam logic [23:0] IO_A = 24'hfffb10;
    localparam logic [23:0] Z0_A = 24'h000100;

    btc_top u_btc_top (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_req(core_req), .core_addr(core_addr), .core_wr(core_wr),
        .core_wide(core_wide), .core_ack_q(core_ack_q), .bus_addr_q(bus_addr_q),
        .bus_phase_q(bus_phase_q), .bus_rd_q(bus_rd_q), .bus_wr_q(bus_wr_q),
        .bus_byte_q(bus_byte_q), .busy_q(busy_q));
    btc_core_model u_btc_core_model (.core_clk(core_clk), .core_ack_q(core_ack_q),
        .core_req(core_req), .core_addr(core_addr), .core_wr(core_wr), .core_wide(core_wide));

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    task automatic print_verdict;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        r = prdata;
        e = pslverr;
        if (k >= 50) begin
            fail_count++;
            $display("[FAIL] %0t register bus hung", $time);
            print_verdict;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, i, d, r, e);
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] x, input logic xe, input string m);
        logic [31:0] r;
        logic        e;
        apb(1'b0, i, 32'h0, r, e);
        chk(r, x, m);
        chk({31'h0, e}, {31'h0, xe}, m);
    endtask
    // one core access, checked against its expected clock count
    task automatic cyc(input logic [23:0] a, input logic w, input logic wd, input int len,
                       input string m);
        int n;
        u_btc_core_model.access(a, w, wd, n);
        chk(n, len + 1, m);
        if (n >= 200) print_verdict;
    endtask

    task automatic t_reset;
        rd(`BTC_IDX_WTS, 32'h07, 1'b0, "wts reset");
        rd(`BTC_IDX_IO, 32'h069f, 1'b0, "io reset");
        rd(`BTC_IDX_Z0, 32'h069f, 1'b0, "z0 reset");
        rd(8'h09, 32'h0, 1'b1, "unmapped");
        cyc(IO_A, 1'b1, 1'b1, 13, "default io write");
    endtask
    task automatic t_late;
        wr(`BTC_IDX_WTS, 32'h06);
        rd(`BTC_IDX_WTS, 32'h06, 1'b0, "wts late");
        for (int w = 0; w < 8; w++) begin
            wr(`BTC_IDX_IO, 32'h0080 | ((w % 4) << 3) | w);
            cyc(IO_A, 1'b1, 1'b1, 2 + w + w % 4, "io wait hold");
        end
        wr(`BTC_IDX_IO, 32'h0080);
        wr(`BTC_IDX_WTS, 32'h07);
        cyc(IO_A, 1'b1, 1'b1, 3, "early write");
        wr(`BTC_IDX_WTS, 32'h06);
    endtask
    task automatic t_z0;
        for (int w = 0; w < 8; w++) begin
            wr(`BTC_IDX_Z0, 32'h0080 | ((3 - w % 4) << 3) | w);
            cyc(Z0_A, 1'b0, 1'b1, 5 + w - w % 4, "z0 wait hold");
        end
        wr(`BTC_IDX_Z0, 32'h089f);
        cyc(Z0_A, 1'b0, 1'b1, 1, "fast read");
    endtask
    task automatic t_width;
        wr(`BTC_IDX_IO, 32'h0000);
        cyc(IO_A, 1'b0, 1'b1, 4, "narrow wide");
        cyc(IO_A, 1'b0, 1'b0, 2, "narrow byte");
        wr(`BTC_IDX_IO, 32'h0080);
        cyc(IO_A, 1'b0, 1'b1, 2, "wide zone");
    endtask
    // burst options on a narrow zone 0, last entry under fast read
    task automatic t_burst;
        logic [15:0] cfg [4] = '{16'h0020, 16'h0060, 16'h0040, 16'h0860};
        int          len [4] = '{3, 4, 4, 2};
        for (int i = 0; i < 4; i++) begin
            wr(`BTC_IDX_Z0, {16'h0, cfg[i]});
            cyc(Z0_A, 1'b0, 1'b1, len[i], "burst");
        end
    endtask
    task automatic t_idle;
        wr(`BTC_IDX_IO, 32'h0280);
        wr(`BTC_IDX_Z0, 32'h0080);
        cyc(IO_A, 1'b1, 1'b1, 2, "to io");
        cyc(Z0_A, 1'b0, 1'b1, 3, "post idle");
        cyc(Z0_A, 1'b0, 1'b1, 2, "same zone");
        wr(`BTC_IDX_Z0, 32'h0480);
        cyc(IO_A, 1'b1, 1'b1, 2, "leave z0");
        cyc(Z0_A, 1'b0, 1'b1, 4, "post and pre idle");
    endtask
    // a write landing mid-cycle must wait for the next cycle
    task automatic t_mid;
        wr(`BTC_IDX_IO, 32'h009f);
        fork
            cyc(IO_A, 1'b1, 1'b1, 12, "old setting held");
            begin
                @(posedge core_clk);
                wr(`BTC_IDX_IO, 32'h0080);
            end
        join
        cyc(IO_A, 1'b1, 1'b1, 2, "new setting");
    endtask

    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h0;
        pwdata = 32'h0;
        fail_count = 0;
        checks = 0;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        t_reset;
        t_late;
        t_z0;
        t_width;
        t_burst;
        t_idle;
        t_mid;
        print_verdict;
    end
    // cut a hang short
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        $display("[FAIL] %0t run did not finish", $time);
        print_verdict;
    end
endmodule // tb
bind btc_top btc_assertions u_btc_assertions (.core_clk(core_clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_ack_q(core_ack_q), .bus_addr_q(bus_addr_q), .bus_phase_q(bus_phase_q),
    .bus_rd_q(bus_rd_q), .bus_wr_q(bus_wr_q), .bus_byte_q(bus_byte_q),
    .busy_q(busy_q));
`default_nettype wire
